// ===== design/cbbc_pkg.sv
// ====================================================================
// constants shared by the execution slice
package cbbc_pkg;

    // ================================================================
    // register byte offsets on the apb window
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam logic [11:0] REG_BANK      = 12'h008;
    localparam logic [11:0] REG_IDX_BASE  = 12'h00C;
    localparam logic [11:0] REG_PC        = 12'h010;
    localparam logic [11:0] REG_INSTR     = 12'h014;
    localparam logic [11:0] REG_EXEC_STAT = 12'h018;
    localparam logic [11:0] REG_MEM_ADDR  = 12'h01C;
    localparam logic [11:0] REG_MEM_DATA  = 12'h020;

    // ================================================================
    // field positions
    localparam int CTRL_EXT_BIT    = 0;   // extended instruction set enable
    localparam int FLAG_CARRY_BIT  = 0;
    localparam int FLAG_ZERO_BIT   = 2;
    localparam int FLAG_OVF_BIT    = 3;
    localparam int FLAG_NEG_BIT    = 4;
    localparam int XS_BUSY_BIT     = 0;
    localparam int XS_TAKEN_BIT    = 1;
    localparam int XS_ILLEGAL_BIT  = 2;
    localparam int XS_CYC_LSB      = 8;

    // ================================================================
    // reset values
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [15:0] INSTR_RST  = 16'h0000;

    // ================================================================
    // opcode encodings (upper byte of the word, upper nibble for bit clear)
    localparam logic [7:0] OP_ZERO_CLEAR  = 8'hE1;
    localparam logic [7:0] OP_CARRY_SET   = 8'hE2;
    localparam logic [7:0] OP_CARRY_CLEAR = 8'hE3;
    localparam logic [7:0] OP_OVF_CLEAR   = 8'hE5;
    localparam logic [7:0] OP_NEG_SET     = 8'hE6;
    localparam logic [7:0] OP_NEG_CLEAR   = 8'hE7;
    localparam logic [3:0] OPN_BIT_CLEAR  = 4'h9;

    // ================================================================
    // addressing constants
    localparam logic [7:0] IDX_LIMIT      = 8'h5F;  // last indexed file address
    localparam logic [7:0] ACCESS_SPLIT   = 8'h80;  // low/high half of access bank
    localparam logic [3:0] ACC_LOW_BANK   = 4'h0;
    localparam logic [3:0] ACC_HIGH_BANK  = 4'hF;

    // ================================================================
    // timing: quarter phases per cycle, one pclk period each
    localparam int          Q_PER_CYCLE = 4;
    localparam logic [1:0]  LAST_Q      = 2'(Q_PER_CYCLE - 1);
    localparam logic [1:0]  PC_STEP     = 2'h2;     // bytes per program word

    // execution phases
    typedef enum logic [2:0] {
        EX_IDLE, EX_DECODE, EX_READ, EX_PROCESS, EX_WRITE, EX_NOP
    } cbbc_state_t;

endpackage : cbbc_pkg

// ===== design/cbbc_decode.sv
`timescale 1ns/1ps
// ====================================================================
// opcode classifier and branch condition test
module cbbc_decode
    import cbbc_pkg::*;
(
    // instruction word
    input  wire logic [15:0] opcode,
    // status flags
    input  wire logic        flag_carry,
    input  wire logic        flag_zero,
    input  wire logic        flag_ovf,
    input  wire logic        flag_neg,
    // classification
    output logic             is_branch,
    output logic             is_bit_clear,
    output logic             take,
    output logic             illegal
);

    // one condition per branch opcode, bit clear by upper nibble
    always_comb begin
        is_branch    = 1'b0;
        is_bit_clear = 1'b0;
        take         = 1'b0;
        illegal      = 1'b0;
        case (opcode[15:8])
            OP_CARRY_SET: begin
                is_branch = 1'b1;
                take      = flag_carry;         // RL1
            end
            OP_NEG_SET: begin
                is_branch = 1'b1;
                take      = flag_neg;           // RL3
            end
            OP_CARRY_CLEAR: begin
                is_branch = 1'b1;
                take      = !flag_carry;        // RL4
            end
            OP_NEG_CLEAR: begin
                is_branch = 1'b1;
                take      = !flag_neg;          // RL5
            end
            OP_OVF_CLEAR: begin
                is_branch = 1'b1;
                take      = !flag_ovf;          // RL6
            end
            OP_ZERO_CLEAR: begin
                is_branch = 1'b1;
                take      = !flag_zero;         // RL8
            end
            default: begin
                if (opcode[15:12] == OPN_BIT_CLEAR) begin
                    is_bit_clear = 1'b1;        // RL13
                end else begin
                    illegal = 1'b1;
                end
            end
        endcase
    end

endmodule : cbbc_decode

// ===== design/cbbc_exec.sv
`timescale 1ns/1ps
// Contract
// RL1: carry-set branch is E2 plus 8-bit offset, taken only when carry is one.
// RL2: carry-set branch redirects when carry is one, else continues sequentially.
// RL3: negative-set branch E6 taken only when negative flag is one.
// RL4: carry-clear branch E3 taken only when carry is zero.
// RL5: negative-clear branch E7 taken only when negative flag is zero.
// RL6: overflow-clear branch E5 taken only when overflow flag is zero.
// RL7: overflow-clear redirects when overflow reads zero, falls through when one.
// RL8: zero-clear branch E1 taken only when zero flag is zero.
// RL9: offset is two's complement, doubled, added to the program counter.
// RL10: target is branch address plus two plus twice offset, -128..127.
// RL11: one word; one cycle not taken, two cycles taken.
// RL12: taken branch writes pc in fourth phase, then a no-operation cycle.
// RL13: bit clear 1001 bbba ffff ffff clears bit b of file register f.
// RL14: bank bit zero selects the access bank.
// RL15: bank bit one selects the bank from the bank select register.
// RL16: bank bit zero with extended set uses indexed offset for f up to 5Fh.
// RL17: flags unchanged; bit clear reads, modifies, writes back in one cycle.
module cbbc_exec
    import cbbc_pkg::*;
#(
    parameter int PC_W   = 21,
    parameter int ADDR_W = 12,
    parameter int BANK_W = 4
) (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // ================================================================
    // state
    localparam int DEPTH = 1 << ADDR_W;

    cbbc_state_t         st_ff;
    logic [7:0]          mem [0:DEPTH-1];
    logic                ext_en_ff;
    logic [7:0]          status_ff;
    logic [BANK_W-1:0]   bank_select_register_ff;
    logic [ADDR_W-1:0]   idx_base_ff;
    logic [PC_W-1:0]     pc_ff;
    logic [15:0]         instr_ff;
    logic                taken_ff;
    logic                illegal_ff;
    logic [3:0]          cyc_ff;
    logic [1:0]          q_ff;
    logic [ADDR_W-1:0]   ea_ff;
    logic [7:0]          rd_ff;
    logic [7:0]          wr_ff;
    logic [ADDR_W-1:0]   mem_addr_ff;
    logic [31:0]         prdata_ff;
    logic                pready_ff;
    logic                pslverr_ff;

    logic                is_branch;
    logic                is_bit_clear;
    logic                take;
    logic                illegal;
    logic                busy;
    logic                wr_ok;
    logic                start;
    logic [ADDR_W-1:0]   nxt_ea;
    logic [PC_W-1:0]     seq_pc;
    logic [PC_W-1:0]     tgt_pc;
    logic [31:0]         nxt_prdata;
    logic                nxt_slverr;

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    // ================================================================
    // decode
    cbbc_decode i_cbbc_decode (
        .opcode       (instr_ff),
        .flag_carry   (status_ff[FLAG_CARRY_BIT]),
        .flag_zero    (status_ff[FLAG_ZERO_BIT]),
        .flag_ovf     (status_ff[FLAG_OVF_BIT]),
        .flag_neg     (status_ff[FLAG_NEG_BIT]),
        .is_branch    (is_branch),
        .is_bit_clear (is_bit_clear),
        .take         (take),
        .illegal      (illegal)
    );

    assign busy = (st_ff != EX_IDLE);

    // next word address and relative target
    assign seq_pc = pc_ff + PC_W'(PC_STEP);
    assign tgt_pc = seq_pc + {{(PC_W-9){instr_ff[7]}}, instr_ff[7:0], 1'b0}; // RL9 RL10

    // effective file address for bit clear
    always_comb begin
        if (instr_ff[8]) begin
            nxt_ea = ADDR_W'({bank_select_register_ff, instr_ff[7:0]});    // RL15
        end else if (ext_en_ff && (instr_ff[7:0] <= IDX_LIMIT)) begin
            nxt_ea = idx_base_ff + ADDR_W'(instr_ff[7:0]);                 // RL16
        end else if (instr_ff[7:0] < ACCESS_SPLIT) begin
            nxt_ea = ADDR_W'({ACC_LOW_BANK, instr_ff[7:0]});               // RL14
        end else begin
            nxt_ea = ADDR_W'({ACC_HIGH_BANK, instr_ff[7:0]});              // RL14
        end
    end

    // ================================================================
    // apb slave: one wait state, answer registered
    assign wr_ok = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign start = wr_ok && (paddr == REG_INSTR);

    // read data and refusal of writes while executing
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = pwrite && busy;
        if (paddr == REG_CTRL) begin
            nxt_prdata[CTRL_EXT_BIT] = ext_en_ff;
        end else if (paddr == REG_STATUS) begin
            nxt_prdata[7:0] = status_ff;
        end else if (paddr == REG_BANK) begin
            nxt_prdata[BANK_W-1:0] = bank_select_register_ff;
        end else if (paddr == REG_IDX_BASE) begin
            nxt_prdata[ADDR_W-1:0] = idx_base_ff;
        end else if (paddr == REG_PC) begin
            nxt_prdata[PC_W-1:0] = pc_ff;
        end else if (paddr == REG_INSTR) begin
            nxt_prdata[15:0] = instr_ff;
        end else if (paddr == REG_EXEC_STAT) begin
            nxt_prdata[XS_BUSY_BIT]             = busy;
            nxt_prdata[XS_TAKEN_BIT]            = taken_ff;
            nxt_prdata[XS_ILLEGAL_BIT]          = illegal_ff;
            nxt_prdata[XS_CYC_LSB+3:XS_CYC_LSB] = cyc_ff;
        end else if (paddr == REG_MEM_ADDR) begin
            nxt_prdata[ADDR_W-1:0] = mem_addr_ff;
        end else if (paddr == REG_MEM_DATA) begin
            nxt_prdata[7:0] = mem[mem_addr_ff];
        end else begin
            nxt_slverr = 1'b1;
        end
    end

    // handshake outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (ce) begin
            if (psel && penable && !pready_ff) begin
                pready_ff  <= 1'b1;
                pslverr_ff <= nxt_slverr;
                prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
            end else begin
                pready_ff  <= 1'b0;
                pslverr_ff <= 1'b0;
                prdata_ff  <= 32'h0000_0000;
            end
        end
    end

    // software configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_en_ff               <= 1'b0;
            status_ff               <= STATUS_RST;
            bank_select_register_ff <= '0;
            idx_base_ff             <= '0;
            mem_addr_ff             <= '0;
        end else if (ce && wr_ok) begin
            if (paddr == REG_CTRL) begin
                ext_en_ff <= pwdata[CTRL_EXT_BIT];
            end else if (paddr == REG_STATUS) begin
                status_ff <= pwdata[7:0];    // only software moves the flags
            end else if (paddr == REG_BANK) begin
                bank_select_register_ff <= pwdata[BANK_W-1:0];
            end else if (paddr == REG_IDX_BASE) begin
                idx_base_ff <= pwdata[ADDR_W-1:0];
            end else if (paddr == REG_MEM_ADDR) begin
                mem_addr_ff <= pwdata[ADDR_W-1:0];
            end
        end
    end

    // ================================================================
    // quarter-phase sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= EX_IDLE;
            q_ff  <= 2'h0;
        end else if (ce) begin
            case (st_ff)
                EX_IDLE: begin
                    if (start) begin
                        st_ff <= EX_DECODE;
                    end
                end
                EX_DECODE: begin
                    st_ff <= illegal ? EX_IDLE : EX_READ;
                end
                EX_READ: begin
                    st_ff <= EX_PROCESS;
                end
                EX_PROCESS: begin
                    st_ff <= EX_WRITE;
                end
                EX_WRITE: begin
                    q_ff  <= 2'h0;
                    st_ff <= (is_branch && take) ? EX_NOP : EX_IDLE;  // RL11 RL12
                end
                EX_NOP: begin
                    q_ff <= q_ff + 2'h1;
                    if (q_ff == LAST_Q) begin
                        st_ff <= EX_IDLE;                            // RL11
                    end
                end
                default: begin
                    st_ff <= EX_IDLE;
                end
            endcase
        end
    end

    // opcode capture and execution results
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_ff   <= INSTR_RST;
            taken_ff   <= 1'b0;
            illegal_ff <= 1'b0;
            cyc_ff     <= 4'h0;
        end else if (ce) begin
            if (start) begin
                instr_ff   <= pwdata[15:0];
                taken_ff   <= 1'b0;
                illegal_ff <= 1'b0;
                cyc_ff     <= 4'h0;
            end else if (st_ff == EX_DECODE && illegal) begin
                illegal_ff <= 1'b1;
            end else if (st_ff == EX_WRITE) begin
                taken_ff <= is_branch && take;
                cyc_ff   <= 4'h1;
            end else if (st_ff == EX_NOP && q_ff == LAST_Q) begin
                cyc_ff <= 4'h2;                                      // RL11
            end
        end
    end

    // program counter: fourth phase of the first cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_ff <= '0;
        end else if (ce) begin
            if (st_ff == EX_WRITE) begin
                pc_ff <= (is_branch && take) ? tgt_pc : seq_pc;     // RL2 RL7 RL12
            end else if (wr_ok && paddr == REG_PC) begin
                pc_ff <= pwdata[PC_W-1:0];
            end
        end
    end

    // read-modify-write datapath for bit clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ea_ff <= '0;
            rd_ff <= 8'h00;
            wr_ff <= 8'h00;
        end else if (ce) begin
            if (st_ff == EX_DECODE) begin
                ea_ff <= nxt_ea;
            end
            if (st_ff == EX_READ) begin
                rd_ff <= mem[ea_ff];                                 // RL17
            end
            if (st_ff == EX_PROCESS) begin
                wr_ff <= rd_ff & ~(8'h01 << instr_ff[11:9]);         // RL13
            end
        end
    end

    // file register array, execution write has priority
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (st_ff == EX_WRITE && is_bit_clear) begin
                mem[ea_ff] <= wr_ff;                                 // RL17
            end else if (wr_ok && paddr == REG_MEM_DATA) begin
                mem[mem_addr_ff] <= pwdata[7:0];
            end
        end
    end

    // ================================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    property p_carry_set;
        (st_ff == EX_WRITE && instr_ff[15:8] == OP_CARRY_SET) |-> (take == status_ff[0]);
    endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry-set condition"); // RL1

    property p_neg_set;
        (st_ff == EX_WRITE && instr_ff[15:8] == OP_NEG_SET) |-> (take == status_ff[4]);
    endproperty
    a_neg_set: assert property (p_neg_set) else $error("negative-set condition"); // RL3

    property p_carry_clear;
        (st_ff == EX_WRITE && instr_ff[15:8] == OP_CARRY_CLEAR) |-> (take != status_ff[0]);
    endproperty
    a_carry_clear: assert property (p_carry_clear) else $error("carry-clear condition"); // RL4

    property p_neg_clear;
        (st_ff == EX_WRITE && instr_ff[15:8] == OP_NEG_CLEAR) |-> (take != status_ff[4]);
    endproperty
    a_neg_clear: assert property (p_neg_clear) else $error("negative-clear condition"); // RL5

    property p_ovf_clear;
        (st_ff == EX_WRITE && instr_ff[15:8] == OP_OVF_CLEAR) |-> (take != status_ff[3]);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow-clear condition"); // RL6

    property p_zero_clear;
        (st_ff == EX_WRITE && instr_ff[15:8] == OP_ZERO_CLEAR) |-> (take != status_ff[2]);
    endproperty
    a_zero_clear: assert property (p_zero_clear) else $error("zero-clear condition"); // RL8

    property p_pc_result;
        (st_ff == EX_WRITE && is_branch) |=> (pc_ff == ($past(take)
            ? $past(pc_ff) + PC_W'(2) + PC_W'(signed'({instr_ff[7:0], 1'b0}))
            : $past(pc_ff) + PC_W'(2)));
    endproperty
    a_pc_result: assert property (p_pc_result) else $error("branch target wrong"); // RL10

    property p_two_cycles;
        (st_ff == EX_WRITE && is_branch && take) |=> (st_ff == EX_NOP)[*4] ##1 !busy;
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("taken not two cycles"); // RL11

    property p_one_cycle;
        (st_ff == EX_DECODE && !illegal && !(is_branch && take)) |-> ##3 st_ff == EX_WRITE ##1 !busy;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("not taken not one cycle"); // RL11

    property p_clear_bit;
        (st_ff == EX_WRITE && is_bit_clear) |=> (mem[$past(ea_ff)][$past(instr_ff[11:9])] == 1'b0);
    endproperty
    a_clear_bit: assert property (p_clear_bit) else $error("bit not cleared"); // RL13

    property p_flags_hold;
        busy |=> $stable(status_ff);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved"); // RL17

    c_taken:     cover property (st_ff == EX_WRITE && is_branch && take);
    c_not_taken: cover property (st_ff == EX_WRITE && is_branch && !take);
    c_indexed:   cover property (st_ff == EX_DECODE && is_bit_clear && ext_en_ff
                                 && !instr_ff[8] && instr_ff[7:0] <= IDX_LIMIT);
    c_refused:   cover property (pready_ff && pslverr_ff);

endmodule : cbbc_exec

// ===== tb/cbbc_exec_tb.sv
`timescale 1ns/1ps
// ====================================================================
// self-checking bench for the branch and bit-clear execution slice
module cbbc_exec_tb;
    import cbbc_pkg::*;

    // ================================================================
    // design ports
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        ce      = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;

    // ================================================================
    // bench state
    int          failures  = 0;
    int          num_checks = 0;
    int          cyc       = 0;
    logic [31:0] rdat;
    logic        rerr;

    cbbc_exec i_cbbc_exec (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    // clock at 50 ns period
    always #25 pclk = ~pclk;

    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one apb transfer, entered just after a rising edge; only the hang guard ends a wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // start an opcode, see busy, then poll until idle
    task automatic run(input logic [15:0] op);
        apb(1'b1, REG_INSTR, {16'h0000, op});
        apb(1'b0, REG_EXEC_STAT, 32'h0000_0000);
        chk("busy", 32'h1, {31'h0, rdat[XS_BUSY_BIT]});
        while (rdat[XS_BUSY_BIT] !== 1'b0) begin
            apb(1'b0, REG_EXEC_STAT, 32'h0000_0000);
        end
    endtask : run

    // ================================================================
    // test tables
    logic [7:0]  ops  [6] = '{OP_CARRY_SET, OP_NEG_SET, OP_CARRY_CLEAR,
                              OP_NEG_CLEAR, OP_OVF_CLEAR, OP_ZERO_CLEAR};
    int          fbit [6] = '{FLAG_CARRY_BIT, FLAG_NEG_BIT, FLAG_CARRY_BIT,
                              FLAG_NEG_BIT, FLAG_OVF_BIT, FLAG_ZERO_BIT};
    logic        trig [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [15:0] bop  [5] = '{16'h9F45, 16'h9010, 16'h9690, 16'h9A5F, 16'h9C60};
    logic        bext [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [11:0] btgt [5] = '{12'h345, 12'h010, 12'hF90, 12'h25F, 12'h060};
    logic [11:0] bdec [5] = '{12'h045, 12'h310, 12'h390, 12'h05F, 12'h260};

    // main sequence
    initial begin
        int         sn;
        int         e;
        logic       v;
        logic       tk;
        logic [7:0] off;
        logic [7:0] st;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values
        apb(1'b0, REG_PC, 32'h0000_0000);
        chk("pc_rst", 32'h0000_0000, rdat);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        chk("status_rst", {24'h0, STATUS_RST}, rdat);
        // every conditional branch, taken and not, at one offset limit each, alternating 7Fh and 80h
        for (int i = 0; i < 6; i++) begin
            for (int k = 0; k < 2; k++) begin
                tk  = k[0];
                v   = tk ? trig[i] : ~trig[i];
                off = i[0] ? 8'h80 : 8'h7F;
                sn  = int'($signed(off));
                st  = {8{~v}} ^ (8'h01 << fbit[i]);
                apb(1'b1, REG_STATUS, {24'h0, st});
                apb(1'b1, REG_PC, 32'h0000_1000);
                run({ops[i], off});
                e = 4096 + 2 + (tk ? 2 * sn : 0);
                apb(1'b0, REG_PC, 32'h0000_0000);
                chk("branch_pc", 32'(e), rdat);
                apb(1'b0, REG_EXEC_STAT, 32'h0000_0000);
                chk("exec_stat", {20'h0, tk ? 4'h2 : 4'h1, 6'h0, tk, 1'b0}, rdat);
                apb(1'b0, REG_STATUS, 32'h0000_0000);
                chk("flags_kept", {24'h0, st}, rdat);
            end
        end
        // write while busy is refused and leaves the pc alone
        apb(1'b1, REG_STATUS, 32'h0000_0000);
        apb(1'b1, REG_PC, 32'h0000_0200);
        apb(1'b1, REG_INSTR, {16'h0000, OP_ZERO_CLEAR, 8'h03});
        apb(1'b1, REG_PC, 32'h0000_0000);
        chk("busy_refuse", 32'h1, {31'h0, rerr});
        // let the taken branch finish before the next start
        do apb(1'b0, REG_EXEC_STAT, 32'h0000_0000); while (rdat[XS_BUSY_BIT] !== 1'b0);
        run({OP_CARRY_CLEAR, 8'h00});
        apb(1'b0, REG_PC, 32'h0000_0000);
        chk("after_refuse", 32'h0000_020A, rdat);
        // unmapped address
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk("unmapped_err", 32'h1, {31'h0, rerr});
        chk("unmapped_data", 32'h0000_0000, rdat);
        // illegal opcode leaves pc unchanged, busy for one pclk only
        apb(1'b1, REG_INSTR, 32'h0000_0000);
        apb(1'b0, REG_EXEC_STAT, 32'h0000_0000);
        chk("illegal", 32'h1, {31'h0, rdat[XS_ILLEGAL_BIT]});
        chk("illegal_busy", 32'h0, {31'h0, rdat[XS_BUSY_BIT]});
        apb(1'b0, REG_PC, 32'h0000_0000);
        chk("illegal_pc", 32'h0000_020A, rdat);
        // bit clear over every addressing path
        apb(1'b1, REG_BANK, 32'h0000_0003);
        apb(1'b1, REG_IDX_BASE, 32'h0000_0200);
        for (int j = 0; j < 5; j++) begin
            apb(1'b1, REG_CTRL, {31'h0, bext[j]});
            apb(1'b1, REG_MEM_ADDR, {20'h0, btgt[j]});
            apb(1'b1, REG_MEM_DATA, 32'h0000_00FF);
            apb(1'b1, REG_MEM_ADDR, {20'h0, bdec[j]});
            apb(1'b1, REG_MEM_DATA, 32'h0000_00FF);
            apb(1'b1, REG_PC, 32'h0000_0040);
            run(bop[j]);
            apb(1'b0, REG_MEM_DATA, 32'h0000_0000);
            chk("decoy", 32'h0000_00FF, rdat);
            apb(1'b1, REG_MEM_ADDR, {20'h0, btgt[j]});
            apb(1'b0, REG_MEM_DATA, 32'h0000_0000);
            chk("cleared", {24'h0, 8'hFF ^ (8'h01 << bop[j][11:9])}, rdat);
            apb(1'b0, REG_PC, 32'h0000_0000);
            chk("bc_pc", 32'h0000_0042, rdat);
            apb(1'b0, REG_EXEC_STAT, 32'h0000_0000);
            chk("bc_cycles", 32'h0000_0100, rdat);
        end
        // clock enable low freezes a taken branch in mid-execution
        apb(1'b1, REG_PC, 32'h0000_0100);
        apb(1'b1, REG_INSTR, {16'h0000, OP_NEG_CLEAR, 8'h01});
        ce <= 1'b0;
        repeat (20) @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, REG_EXEC_STAT, 32'h0000_0000);
        chk("frozen_busy", 32'h1, {31'h0, rdat[XS_BUSY_BIT]});
        while (rdat[XS_BUSY_BIT] !== 1'b0) begin
            apb(1'b0, REG_EXEC_STAT, 32'h0000_0000);
        end
        apb(1'b0, REG_PC, 32'h0000_0000);
        chk("frozen_pc", 32'h0000_0104, rdat);
        apb(1'b0, REG_EXEC_STAT, 32'h0000_0000);
        chk("frozen_cycles", 32'h0000_0202, rdat);
        print_verdict();
    end

endmodule : cbbc_exec_tb
